// [logic/nap_event_bit.sv]
`timescale 1ns/100ps
`default_nettype none
module nap_event_bit
  import nap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Control
  input wire logic flush,
  input wire logic set,
  input wire logic clr,
  // State
  output logic q
);
  logic q_reg;

  // Set beats a simultaneous write-one clear so no event is lost
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q_reg <= 1'b0;
    else if (ce)
    begin
      if (flush)
        q_reg <= 1'b0;
      else if (set)
        q_reg <= 1'b1;
      else if (clr)
        q_reg <= 1'b0;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// [logic/nap_pkg.sv]
`default_nettype none
package nap_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [2:0] OFF_CMD = 3'h0;
  localparam logic [2:0] OFF_STAT = 3'h2;
  localparam logic [2:0] OFF_PCB_LO = 3'h4;
  localparam logic [2:0] OFF_PCB_HI = 3'h6;

  // ************************************************************
  // Command register fields
  // ************************************************************
  localparam int BIT_ISUM = 7;
  localparam int BIT_IEN = 6;
  localparam int BIT_SRST = 5;
  // Event bit indices within the upper byte
  localparam int EV_USTATE = 0;
  localparam int EV_ZERO = 1;
  localparam int EV_NOBUF = 2;
  localparam int EV_DONE = 3;
  localparam int EV_TX = 4;
  localparam int EV_RX = 5;
  localparam int EV_CERR = 6;
  localparam int EV_SERR = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ************************************************************
  // Adapter state codes
  // ************************************************************
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] ST_PLOAD = 4'h1;
  localparam logic [3:0] ST_READY = 4'h2;
  localparam logic [3:0] ST_RUN = 4'h3;
  localparam logic [3:0] ST_HOST_HALT = 4'h5;
  localparam logic [3:0] ST_NET_HALT = 4'h6;
  localparam logic [3:0] ST_BOTH_HALT = 4'h7;

  // ************************************************************
  // Port command codes
  // ************************************************************
  localparam logic [3:0] PC_NOP = 4'h0;
  localparam logic [3:0] PC_FETCH_PTR = 4'h1;
  localparam logic [3:0] PC_GET_CMD = 4'h2;
  localparam logic [3:0] PC_SELFTEST = 4'h3;
  localparam logic [3:0] PC_START = 4'h4;
  localparam logic [3:0] PC_BOOT = 4'h5;
  localparam logic [3:0] PC_RSVD6 = 4'h6;
  localparam logic [3:0] PC_RSVD7 = 4'h7;
  localparam logic [3:0] PC_POLL = 4'h8;
  localparam logic [3:0] PC_STOP = 4'hf;

  // ************************************************************
  // Self-test and bug check result codes
  // ************************************************************
  localparam logic [5:0] TEST_PASS = 6'h00;
  localparam logic [5:0] BUG_RESTART = 6'h01;
  localparam logic [5:0] BUG_UNEXP_INT = 6'h02;
  localparam logic [5:0] BUG_PARITY = 6'h03;
  localparam logic [5:0] BUG_TXALLOC = 6'h04;
  localparam logic [5:0] BUG_TXALLOC_BOOT = 6'h29;
  localparam logic [2:0] BSEL_RESTART = 3'h0;
  localparam logic [2:0] BSEL_UNEXP_INT = 3'h1;
  localparam logic [2:0] BSEL_PARITY = 3'h2;
  localparam logic [2:0] BSEL_TXALLOC = 3'h3;

  // ************************************************************
  // Control block function codes and classes
  // ************************************************************
  localparam logic [7:0] FN_LAST_BASIC = 8'h0e;
  localparam logic [7:0] FN_LAST_MAINT = 8'h15;
  localparam logic [3:0] FC_NOP = 4'h0;
  localparam logic [3:0] FC_LOAD_START = 4'h1;
  localparam logic [3:0] FC_READ_DEFAULT = 4'h2;
  localparam logic [3:0] FC_STATION = 4'h3;
  localparam logic [3:0] FC_MULTICAST = 4'h4;
  localparam logic [3:0] FC_RING = 4'h5;
  localparam logic [3:0] FC_COUNTERS = 4'h6;
  localparam logic [3:0] FC_MODE = 4'h7;
  localparam logic [3:0] FC_STATUS = 4'h8;
  localparam logic [3:0] FC_MAINT = 4'h9;
  localparam logic [3:0] FC_ILLEGAL = 4'hf;

  // ************************************************************
  // Command sequencer states
  // ************************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_MEM = 5'h02,
    S_FUNC = 5'h04,
    S_TEST = 5'h08,
    S_BOOT = 5'h10
  } nap_fsm_t;
endpackage
`default_nettype wire

// [logic/nap_port_csr.sv]
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1 - After a good reset the state field shows ready, reset state is transient.
// RL2 - Self-test pass: result zero, state ready, done flag set.
// RL3 - Self-test fail: result field takes the nonzero failing-test code.
// RL4 - Fatal bug check halts both sides and reports its cause code.
// RL5 - Read-only bits ignore writes; write-only bits read as zero.
// RL6 - Low pointer register used as an even address.
// RL7 - High pointer register keeps two bits; upper bits read zero.
// RL8 - Any event sets summary; interrupt raised only with enable set.
// RL9 - Event bits clear on write one; zero leaves them.
// RL10 - Host uses no-op only with enable change or reset, then waits 100 us.
// RL11 - A write changing interrupt enable leaves the command field unchanged.
// RL12 - Host changes enable and issues command in two separate writes.
// RL13 - Host clears the event byte with a byte write.
// RL14 - Non-no-op commands start on fetch, end with done or error flag.
// RL15 - Only one port command executes at a time.
// RL16 - Control block read by bus master at the 18-bit base.
// RL17 - Function code in word 0 is only read, never modified.
// RL18 - Function codes decode into their documented classes.
// RL19 - State field uses the documented four-bit encoding.
// RL20 - Port command field uses the documented encoding; others act as no-op. Codes 9 to 14 still raise the done flag here.
// RL21 - Interrupt enable is changed only by host writes.
// RL22 - Registers at byte offsets 0, 2, 4, 6 with word or byte writes.
// RL23 - One clock; power-up clears events, summary and enable.
module nap_port_csr
  import nap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Host register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic host_irq,
  // Control block bus master read
  output logic mem_req,
  output logic [17:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [15:0] mem_rdata,
  // Function executor
  output logic func_start,
  output logic [7:0] func_code,
  output logic [3:0] func_class,
  input wire logic func_done,
  input wire logic func_err,
  // Self-test engine
  output logic selftest_start,
  input wire logic selftest_done,
  input wire logic [5:0] selftest_code,
  // Boot loader
  input wire logic boot_loaded,
  // Network side events and control
  input wire logic ev_status_err,
  input wire logic ev_rx_ring,
  input wire logic ev_tx_ring,
  input wire logic ev_rx_discard,
  input wire logic bug_check,
  input wire logic [2:0] bug_cause,
  output logic ring_reset,
  output logic poll_demand,
  output logic net_halt,
  output logic host_halt,
  // Bulkhead status pins
  input wire logic xcvr_fault_pin,
  input wire logic cable_fault_pin
);
  // ************************************************************
  // Declarations
  // ************************************************************
  nap_fsm_t fsm_reg;
  nap_fsm_t fsm_next;
  logic [3:0] state_reg;
  logic [3:0] state_next;
  logic [5:0] code_reg;
  logic [5:0] code_next;
  logic btmo_reg;
  logic btmo_next;
  logic [3:0] cmd_reg;
  logic ien_reg;
  logic pend_reg;
  logic init_reg;
  logic nobuf_arm_reg;
  logic [15:0] pcb_lo_reg;
  logic [1:0] pcb_hi_reg;
  logic [17:0] pcb_copy_reg;
  logic mem_req_reg;
  logic func_start_reg;
  logic [7:0] func_code_reg;
  logic [3:0] func_class_reg;
  logic selftest_start_reg;
  logic ring_reset_reg;
  logic poll_reg;
  logic irq_reg;
  logic [15:0] rdata_reg;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic done_set;
  logic cerr_set;
  logic ustate_set;
  logic [7:0] ev_q;

  // ************************************************************
  // Register decode
  // ************************************************************
  // RL22 word offsets
  wire [2:0] word_addr = {reg_addr[2:1], 1'b0};
  wire wr_cmd_lo = reg_wr && (word_addr == OFF_CMD) && reg_be[0];
  wire wr_cmd_hi = reg_wr && (word_addr == OFF_CMD) && reg_be[1];
  wire wr_lo_b0 = reg_wr && (word_addr == OFF_PCB_LO) && reg_be[0];
  wire wr_lo_b1 = reg_wr && (word_addr == OFF_PCB_LO) && reg_be[1];
  wire wr_hi = reg_wr && (word_addr == OFF_PCB_HI) && reg_be[0];
  // RL11 enable change locks command field
  wire ien_change = wr_cmd_lo && (reg_wdata[BIT_IEN] != ien_reg);
  wire soft_rst_wr = wr_cmd_lo && reg_wdata[BIT_SRST];
  wire init = init_reg || soft_rst_wr;
  wire cmd_load = wr_cmd_lo && !ien_change && !init;
  wire [3:0] cmd_wr = reg_wdata[3:0];
  // RL20 no-op class codes raise no done flag
  wire cmd_wr_nop = (cmd_wr == PC_NOP) || (cmd_wr == PC_RSVD6) || (cmd_wr == PC_RSVD7);

  // RL19 halted states
  wire halted = (state_reg == ST_HOST_HALT) || (state_reg == ST_NET_HALT)
    || (state_reg == ST_BOTH_HALT);
  // RL15 take a command only when idle
  wire take = pend_reg && (fsm_reg == S_IDLE) && !halted && !init && !bug_check;
  wire take_poll = take && (cmd_reg == PC_POLL);
  wire take_start = take && (cmd_reg == PC_START) && (state_reg != ST_RUN);
  wire test_launch = init || (take && (cmd_reg == PC_SELFTEST));

  // RL4 bug check cause codes
  wire [5:0] bug_code = (bug_cause == BSEL_RESTART) ? BUG_RESTART :
    (bug_cause == BSEL_UNEXP_INT) ? BUG_UNEXP_INT :
    (bug_cause == BSEL_PARITY) ? BUG_PARITY :
    (bug_cause == BSEL_TXALLOC) ? BUG_TXALLOC : BUG_TXALLOC_BOOT;

  // RL18 function code classes
  wire [7:0] fn = mem_rdata[7:0];
  wire [3:0] fn_class = (fn == 8'h00 || fn == 8'h03) ? FC_NOP :
    (fn == 8'h01) ? FC_LOAD_START :
    (fn == 8'h02) ? FC_READ_DEFAULT :
    (fn == 8'h04 || fn == 8'h05) ? FC_STATION :
    (fn == 8'h06 || fn == 8'h07) ? FC_MULTICAST :
    (fn == 8'h08 || fn == 8'h09) ? FC_RING :
    (fn == 8'h0a || fn == 8'h0b) ? FC_COUNTERS :
    (fn == 8'h0c || fn == 8'h0d) ? FC_MODE :
    (fn == FN_LAST_BASIC) ? FC_STATUS :
    (fn <= FN_LAST_MAINT) ? FC_MAINT : FC_ILLEGAL;
  wire fn_fetched = (fsm_reg == S_MEM) && mem_ack && !mem_err;

  // ************************************************************
  // Event bits
  // ************************************************************
  // No-buffer event stays quiet after firing until a polling demand or a reset re-arms it
  wire nobuf_set = ev_rx_discard && nobuf_arm_reg;
  wire [7:0] ev_set = {ev_status_err, cerr_set, ev_rx_ring, ev_tx_ring,
    done_set, nobuf_set, 1'b0, ustate_set};
  // RL9 write one to clear
  wire [7:0] ev_clr = {8{wr_cmd_hi}} & reg_wdata[15:8];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_ev
      if (gi == EV_ZERO)
      begin : g_zero
        assign ev_q[gi] = 1'b0;
      end
      else
      begin : g_bit
        nap_event_bit u_bit (
          .clk(clk),
          .nrst(nrst),
          .ce(ce),
          .flush(init),
          .set(ev_set[gi]),
          .clr(ev_clr[gi]),
          .q(ev_q[gi])
        );
      end
    end
  endgenerate

  // RL8 summary bit
  wire irq_sum = |ev_q;

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always_comb
  begin
    fsm_next = fsm_reg;
    state_next = state_reg;
    code_next = code_reg;
    btmo_next = btmo_reg;
    done_set = 1'b0;
    cerr_set = 1'b0;
    ustate_set = 1'b0;
    if (init)
    begin
      // RL1 reset state held until self-test passes
      state_next = ST_RESET;
      code_next = TEST_PASS;
      btmo_next = 1'b0;
      fsm_next = S_TEST;
    end
    else if (bug_check)
    begin
      // RL4 fatal error halts both sides
      state_next = ST_BOTH_HALT;
      code_next = bug_code;
      ustate_set = 1'b1;
      fsm_next = S_IDLE;
    end
    else
    begin
      unique case (fsm_reg)
        S_IDLE:
          if (take)
          begin
            btmo_next = 1'b0;
            // RL14 execution begins on command fetch
            case (cmd_reg)
              PC_GET_CMD: fsm_next = S_MEM;
              PC_SELFTEST:
              begin
                state_next = ST_RESET;
                fsm_next = S_TEST;
              end
              PC_START:
              begin
                if (state_reg != ST_RUN)
                  state_next = ST_RUN;
                done_set = 1'b1;
              end
              PC_BOOT:
              begin
                state_next = ST_PLOAD;
                fsm_next = S_BOOT;
              end
              PC_STOP:
              begin
                if (state_reg == ST_RUN)
                  state_next = ST_READY;
                done_set = 1'b1;
              end
              default: done_set = 1'b1;
            endcase
          end
        S_MEM:
          if (mem_err)
          begin
            // Bus timeout ends the command with an error
            cerr_set = 1'b1;
            btmo_next = 1'b1;
            fsm_next = S_IDLE;
          end
          else if (mem_ack)
          begin
            if (fn_class == FC_NOP)
            begin
              done_set = 1'b1;
              fsm_next = S_IDLE;
            end
            else
              fsm_next = S_FUNC;
          end
        S_FUNC:
          if (func_err)
          begin
            cerr_set = 1'b1;
            fsm_next = S_IDLE;
          end
          else if (func_done)
          begin
            done_set = 1'b1;
            fsm_next = S_IDLE;
          end
        S_TEST:
          if (selftest_done)
          begin
            // RL2 RL3 result field and completion flag
            code_next = selftest_code;
            if (selftest_code == TEST_PASS)
            begin
              state_next = ST_READY;
              done_set = 1'b1;
            end
            else
              cerr_set = 1'b1;
            fsm_next = S_IDLE;
          end
        S_BOOT:
          if (boot_loaded)
          begin
            state_next = ST_READY;
            done_set = 1'b1;
            fsm_next = S_IDLE;
          end
        default: fsm_next = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fsm_reg <= S_IDLE;
      state_reg <= ST_RESET;
      code_reg <= TEST_PASS;
      btmo_reg <= 1'b0;
    end
    else if (ce)
    begin
      fsm_reg <= fsm_next;
      state_reg <= state_next;
      code_reg <= code_next;
      btmo_reg <= btmo_next;
    end
  end

  // ************************************************************
  // Host-written control
  // ************************************************************
  // Power-up runs the same self-test path as a soft reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_reg <= 1'b1;
      ien_reg <= 1'b0;
      cmd_reg <= PC_NOP;
      pend_reg <= 1'b0;
      nobuf_arm_reg <= 1'b1;
    end
    else if (ce)
    begin
      init_reg <= 1'b0;
      // RL21 RL23 enable follows host writes only; power-up and soft reset clear it
      ien_reg <= init ? 1'b0 : (wr_cmd_lo ? reg_wdata[BIT_IEN] : ien_reg);
      // RL11 command field kept when enable changes
      cmd_reg <= init ? PC_NOP : (cmd_load ? cmd_wr : cmd_reg);
      // RL15 a new command waits until the sequencer is idle
      if (init || halted)
        pend_reg <= 1'b0;
      else if (cmd_load && !cmd_wr_nop)
        pend_reg <= 1'b1;
      else if (take)
        pend_reg <= 1'b0;
      if (init || take_poll)
        nobuf_arm_reg <= 1'b1;
      else if (nobuf_set)
        nobuf_arm_reg <= 1'b0;
    end
  end

  // Pointer is data only; cleared at reset for repeatable simulation
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pcb_lo_reg <= 16'h0000;
      pcb_hi_reg <= 2'h0;
      pcb_copy_reg <= 18'h00000;
    end
    else if (ce)
    begin
      if (wr_lo_b0)
        pcb_lo_reg[7:0] <= reg_wdata[7:0];
      if (wr_lo_b1)
        pcb_lo_reg[15:8] <= reg_wdata[15:8];
      // RL7 only two high bits stored
      if (wr_hi)
        pcb_hi_reg <= reg_wdata[1:0];
      // RL6 RL16 latched base forced even
      if (take && (cmd_reg == PC_FETCH_PTR))
        pcb_copy_reg <= {pcb_hi_reg, pcb_lo_reg[15:1], 1'b0};
    end
  end

  // ************************************************************
  // Outputs to the rest of the adapter
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_req_reg <= 1'b0;
      func_start_reg <= 1'b0;
      func_code_reg <= 8'h00;
      func_class_reg <= FC_NOP;
      selftest_start_reg <= 1'b0;
      ring_reset_reg <= 1'b0;
      poll_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      // RL16 control block read request
      mem_req_reg <= (fsm_next == S_MEM);
      // RL17 function code only captured, never written back
      func_start_reg <= fn_fetched && (fn_class != FC_NOP) && !init && !bug_check;
      if (fn_fetched)
      begin
        func_code_reg <= fn;
        func_class_reg <= fn_class;
      end
      selftest_start_reg <= test_launch;
      ring_reset_reg <= take_start;
      poll_reg <= take_poll;
      // RL8 single interrupt gated by enable
      irq_reg <= irq_sum && ien_reg;
    end
  end

  assign mem_req = mem_req_reg;
  assign mem_addr = pcb_copy_reg;
  assign func_start = func_start_reg;
  assign func_code = func_code_reg;
  assign func_class = func_class_reg;
  assign selftest_start = selftest_start_reg;
  assign ring_reset = ring_reset_reg;
  assign poll_demand = poll_reg;
  assign host_irq = irq_reg;
  assign net_halt = (state_reg == ST_NET_HALT) || (state_reg == ST_BOTH_HALT);
  assign host_halt = (state_reg == ST_HOST_HALT) || (state_reg == ST_BOTH_HALT);

  // ************************************************************
  // Status pins and read path
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end
    else if (ce)
    begin
      pin_meta_reg <= {xcvr_fault_pin, cable_fault_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // RL5 reset and unused bits read as zero
  wire [15:0] rd_cmd = {ev_q, irq_sum, ien_reg, 2'h0, cmd_reg};
  wire [15:0] rd_stat = {pin_sync_reg, code_reg, btmo_reg, 3'h0, state_reg};
  // RL7 upper bits of the high pointer read zero
  wire [15:0] rd_hi = {14'h0000, pcb_hi_reg};
  wire [15:0] rd_mux = (word_addr == OFF_CMD) ? rd_cmd :
    (word_addr == OFF_STAT) ? rd_stat :
    (word_addr == OFF_PCB_LO) ? pcb_lo_reg : rd_hi;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= CMD_RESET;
    else if (ce && reg_rd)
      rdata_reg <= rd_mux;
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_irq_gate: assert property ( // RL8
    ce && irq_sum && ien_reg |=> host_irq)
    else $error("interrupt not raised with enable set");
  chk_cmd_interlock: assert property ( // RL11
    ce && ien_change && !init |=> cmd_reg == $past(cmd_reg))
    else $error("command field changed with enable");
  chk_w1c_clear: assert property ( // RL9
    ce && wr_cmd_hi && reg_wdata[8 + EV_TX] && !ev_tx_ring && !init |=> !ev_q[EV_TX])
    else $error("event bit not cleared by write one");
  chk_wo_zero: assert property ( // RL5
    ce && reg_rd && word_addr == OFF_CMD |=> reg_rdata[5:4] == 2'h0 && !reg_rdata[9])
    else $error("write-only bit read nonzero");
  chk_pcb_even: assert property ( // RL6
    mem_req |-> !mem_addr[0])
    else $error("control block address odd");
  chk_hi_zero: assert property ( // RL7
    ce && reg_rd && word_addr == OFF_PCB_HI |=> reg_rdata[15:2] == 14'h0000)
    else $error("high pointer upper bits nonzero");
  chk_test_pass: assert property ( // RL2
    ce && fsm_reg == S_TEST && selftest_done && selftest_code == TEST_PASS
    && !init && !bug_check |=> state_reg == ST_READY && ev_q[EV_DONE] && code_reg == 6'h00)
    else $error("self-test pass not reported");
  chk_fatal_halt: assert property ( // RL4
    ce && bug_check && !init |=> net_halt && host_halt && ev_q[EV_USTATE])
    else $error("bug check did not halt");
  chk_one_cmd: assert property ( // RL15
    ce && fsm_reg == S_FUNC && !func_done && !func_err && !init && !bug_check
    |=> fsm_reg == S_FUNC)
    else $error("command taken while busy");
endmodule
`default_nettype wire

// [sim/nap_partner.sv]
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Host memory, function executor and self-test engine
// ************************************************************
module nap_partner
  import nap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Requests
  input wire logic mem_req,
  input wire logic func_start,
  input wire logic selftest_start,
  // Scenario settings
  input wire logic [15:0] word0,
  input wire logic [5:0] st_code,
  // Answers
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic func_done,
  output logic func_err,
  output logic selftest_done,
  output logic [5:0] selftest_code
);
  logic [3:0] cnt_reg;
  logic [1:0] kind_reg;
  logic slow_reg;
  assign func_err = 1'b0;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 4'h0;
      kind_reg <= 2'h0;
      slow_reg <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      func_done <= 1'b0;
      selftest_done <= 1'b0;
      selftest_code <= 6'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      func_done <= 1'b0;
      selftest_done <= 1'b0;
      // Idle bus toggles so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (cnt_reg > 4'h1)
        cnt_reg <= cnt_reg - 4'h1;
      else if (cnt_reg == 4'h1)
      begin
        cnt_reg <= 4'h0;
        mem_ack <= kind_reg == 2'h0;
        func_done <= kind_reg == 2'h1;
        selftest_done <= kind_reg == 2'h2;
        if (kind_reg == 2'h0)
          mem_rdata <= word0;
        selftest_code <= st_code;
      end
      else if ((mem_req && !mem_ack) || func_start || selftest_start)
      begin
        kind_reg <= mem_req ? 2'h0 : (func_start ? 2'h1 : 2'h2);
        // Alternate prompt and slow answers
        cnt_reg <= slow_reg ? 4'h7 : 4'h1;
        slow_reg <= ~slow_reg;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import nap_pkg::*;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, bug_check = 0, rd_q = 0, mq = 0;
  logic [2:0] reg_addr = 0, bug_cause = 0;
  logic [1:0] reg_be = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, mem_rdata, word0 = 0, lo, hi;
  logic [31:0] seed = 32'd90861;
  logic [3:0] ev = 0, func_class;
  logic [5:0] st_code = 0, selftest_code;
  logic [7:0] func_code;
  logic [17:0] mem_addr, pend[$];
  logic host_irq, mem_req, mem_ack, func_start, func_done, func_err, selftest_start;
  logic selftest_done, ring_reset, poll_demand, net_halt, host_halt;
  int errors = 0, checks_done = 0;
  initial forever #5 clk = ~clk;
  nap_port_csr nap_port_csr_inst (.clk, .nrst, .ce(1'b1), .reg_addr, .reg_wr, .reg_rd, .reg_be,
    .reg_wdata, .reg_rdata, .host_irq, .mem_req, .mem_addr, .mem_ack, .mem_err(1'b0), .mem_rdata,
    .func_start, .func_code, .func_class, .func_done, .func_err, .selftest_start, .selftest_done,
    .selftest_code, .boot_loaded(1'b0), .ev_status_err(ev[3]), .ev_rx_ring(ev[2]),
    .ev_tx_ring(ev[1]), .ev_rx_discard(ev[0]), .bug_check, .bug_cause, .ring_reset, .poll_demand,
    .net_halt, .host_halt, .xcvr_fault_pin(1'b0), .cable_fault_pin(1'b0));
  nap_partner nap_partner_inst (.clk, .nrst, .mem_req, .func_start, .selftest_start, .word0,
    .st_code, .mem_ack, .mem_rdata, .func_done, .func_err, .selftest_done, .selftest_code);
  // ************************************************************
  // Shared tasks
  // ************************************************************
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [3:0] fcls(input logic [7:0] f);
    case (f)
      8'h01: return FC_LOAD_START;
      8'h02: return FC_READ_DEFAULT;
      8'h04, 8'h05: return FC_STATION;
      8'h06, 8'h07: return FC_MULTICAST;
      8'h08, 8'h09: return FC_RING;
      8'h0a, 8'h0b: return FC_COUNTERS;
      8'h0c, 8'h0d: return FC_MODE;
      default: return FC_STATUS;
    endcase
  endfunction
  task summarize();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1;
    idle(1);
    reg_wr = 0;
    idle(1);
  endtask
  task rd(input logic [2:0] a, input logic [17:0] e);
    pend.push_back(e);
    reg_addr = a;
    reg_rd = 1;
    idle(1);
    reg_rd = 0;
    idle(1);
  endtask
  task wait_evt();
    int n;
    for (n = 0; n < 200 && !(selftest_done === 1'b1 || func_done === 1'b1); n++)
      @(negedge clk);
    if (n == 200)
    begin
      errors++;
      summarize();
    end
    idle(4);
  endtask
  always @(posedge clk)
  begin
    rd_q <= reg_rd;
    mq <= mem_req;
  end
  always @(negedge clk)
  begin
    if (rd_q) chk({2'h0, reg_rdata}, pend.pop_front());
    if (mem_req && !mq) chk(mem_addr, pend.pop_front());
    if (func_start) chk({6'h0, func_class, func_code}, pend.pop_front());
  end
  initial
  begin
    int f;
    idle(16);
    nrst = 1;
    wait_evt();
    rd(OFF_CMD, 18'h00880);
    rd(OFF_STAT, {14'h0, ST_READY});
    wr(OFF_CMD, 2'b10, 16'hff00);
    rd(OFF_CMD, 18'h0);
    wr(OFF_CMD, 2'b01, 16'h0041);
    rd(OFF_CMD, 18'h00040);
    chk({17'h0, host_irq}, 18'h0);
    lo = xs();
    hi = xs();
    wr(OFF_PCB_LO, 2'b11, lo);
    wr(OFF_PCB_HI, 2'b11, hi);
    rd(OFF_PCB_HI, {16'h0, hi[1:0]});
    wr(OFF_STAT, 2'b11, 16'hffff);
    rd(OFF_STAT, {14'h0, ST_READY});
    wr(OFF_CMD, 2'b01, 16'h0041);
    idle(3);
    rd(OFF_CMD, 18'h008c1);
    chk({17'h0, host_irq}, 18'h1);
    wr(OFF_CMD, 2'b01, 16'h0044);
    chk({17'h0, ring_reset}, 18'h1);
    wr(OFF_CMD, 2'b01, 16'h0048);
    chk({17'h0, poll_demand}, 18'h1);
    for (f = 1; f < 15; f++)
    begin
      if (f == 3)
        continue;
      word0 = {8'h00, f[7:0]};
      pend.push_back({hi[1:0], lo[15:1], 1'b0});
      pend.push_back({6'h0, fcls(f[7:0]), f[7:0]});
      wr(OFF_CMD, 2'b01, 16'h0042);
      wait_evt();
    end
    rd(OFF_CMD, 18'h008c2);
    ev = 4'hf;
    bug_check = 1;
    bug_cause = BSEL_PARITY;
    idle(1);
    ev = 4'h0;
    bug_check = 0;
    idle(3);
    rd(OFF_STAT, {4'h0, BUG_PARITY, 4'h0, ST_BOTH_HALT});
    rd(OFF_CMD, 18'h0bdc2);
    chk({16'h0, net_halt, host_halt}, 18'h3);
    st_code = 6'h3e;
    wr(OFF_CMD, 2'b01, 16'h0020);
    wait_evt();
    rd(OFF_STAT, {4'h0, 6'h3e, 8'h00});
    rd(OFF_CMD, 18'h04080);
    summarize();
  end
endmodule
`default_nettype wire
